// *** rtl/lp_ctrl_pkg.sv ***
// package: constants and types of the low power clock and link control block
package lp_ctrl_pkg;
  // apb register byte offsets
  localparam logic [7:0] CLOCK_MODE_OFS = 8'h00;
  localparam logic [7:0] CORE1_PWR_OFS = 8'h04;
  localparam logic [7:0] CORE2_PWR_OFS = 8'h08;
  localparam logic [7:0] LINK_CTRL_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] PENDING_OFS = 8'h14;
  // clock mode register fields
  localparam int HOST_MODE_LSB = 0;
  localparam int XTAL_FORCE_BIT = 2;
  // core power register fields
  localparam int PWR_DOWN_BIT = 0;
  localparam int PWR_UP_BIT = 1;
  // link control register fields
  localparam int LINK_EN_BIT = 0;
  localparam int WAKE_RESTART_BIT = 1;
  localparam int LINK_COLD_BIT = 2;
  localparam int LINK_WARM_BIT = 3;
  localparam int WAKE_SEEN_BIT = 4;
  // reset values
  localparam logic [2:0] CLOCK_MODE_RST = 3'h0;
  localparam logic [1:0] LINK_CTRL_RST = 2'h0;
  // host interface modes
  typedef enum logic [1:0] {
    HOST_PCI = 2'b00,
    HOST_CARDBUS = 2'b01,
    HOST_USB = 2'b10,
    HOST_SUBISA = 2'b11
  } host_mode_t;
  // link states
  typedef enum logic [2:0] {
    LINK_COLD = 3'b000,
    LINK_WARM = 3'b001,
    LINK_WAKE = 3'b010,
    LINK_IDLE = 3'b011,
    LINK_RUN = 3'b100
  } link_state_t;
  // core power states
  typedef enum logic [1:0] {
    CORE_RUN = 2'b00,
    CORE_HANDLER = 2'b01,
    CORE_DOWN = 2'b10
  } core_state_t;
  // timing: warm wake sync pulse
  localparam int CLK_MHZ = 125;
  localparam int WAKE_SYNC_NS = 1000;
  localparam int WAKE_SYNC_CYC = (WAKE_SYNC_NS * CLK_MHZ + 999) / 1000;
  // frame geometry: slot 12 bit 0 position in a 256 bit frame
  localparam int FRAME_BITS = 256;
  localparam int WAKE_BIT_POS = 16 + 12 * 20 - 1;
  // interrupt handler vector
  localparam logic [15:0] PWR_VECTOR = 16'h002c;
endpackage : lp_ctrl_pkg

// *** rtl/pin_sync3.sv ***
// module: three flop pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // pin in, filtered level out
  input wire logic pinIn,
  output logic pinOut
);
  // ****************************************
  // synchroniser stages
  // ****************************************
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_t;
  sync_t st_q, st_d;
  // next state: level only changes when stages two and three agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = pinIn;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end
  // register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign pinOut = st_q.lvl;
endmodule // pin_sync3
`default_nettype wire

// *** rtl/lp_clock_link_ctrl.sv ***
// module: low power clock gating decision, codec link sequencing, core powerdown
// Summary of operation
// - pci/cardbus: ignore clock when all down, no force
// - usb mode also needs usb suspended
// - sub-isa mode never ignores the clock
// - irqs during core powerdown latched, serviced later
// - cold state: reset asserted, bitclk and sync stopped
// - warm state: clocks stopped, reset deasserted
// - cold release starts bitclk, sync waits enable
// - bitclk running without sync is idle state
// - running link: wake is slot 12 bit 0
// - other states: wake is high data input
// - wake restarts link only when enabled
// - powerdown irq unmaskable, blocked by global disable
// - core stops clocks only at idle instruction
// - return before idle cancels the powerdown
// - powerdown handler starts at fixed vector
// - enable in warm: sync pulse one microsecond
// - powerdown/powerup request bits drive core handler
`timescale 1ns/1ns
`default_nettype none
module lp_clock_link_ctrl #(
  parameter int NUM_IRQ = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host interface status
  input wire logic usbSuspended,
  // codec link pins
  input wire logic bitClkPin,
  input wire logic serialDataIn,
  output logic codecLinkResetN,
  output logic bitClkEnable,
  output logic frameSync,
  // core 1 sequencer handshake
  input wire logic core1IdleExec,
  input wire logic core1RtiExec,
  input wire logic core1IntsDisabled,
  output logic core1PwrIrq,
  output logic [15:0] core1PwrVector,
  output logic core1ClkStop,
  // core 2 sequencer handshake
  input wire logic core2IdleExec,
  input wire logic core2RtiExec,
  input wire logic core2IntsDisabled,
  output logic core2PwrIrq,
  output logic [15:0] core2PwrVector,
  output logic core2ClkStop,
  // peripheral interrupts to both cores
  input wire logic [NUM_IRQ-1:0] irqIn,
  input wire logic [1:0] irqAck,
  output logic [NUM_IRQ-1:0] core1IrqPend,
  output logic [NUM_IRQ-1:0] core2IrqPend,
  // clock gating result
  output logic extClkIgnore
);
  // ****************************************
  // state record
  // ****************************************
  typedef struct packed {
    logic [2:0] clkMode;                   // host mode and crystal force
    lp_ctrl_pkg::core_state_t [1:0] core;  // per core power state
    logic [1:0] pdReq;                     // pending powerdown requests
    logic [1:0] irqOut;                    // powerdown irq being signalled
    logic [1:0] linkCtl;                   // link enable, wake restart enable
    lp_ctrl_pkg::link_state_t link;        // link sequencer state
    logic [7:0] syncCnt;                   // wake sync pulse timer
    logic [7:0] bitCnt;                    // bit position in frame
    logic bitClkPrev;                      // previous filtered bitclk
    logic wakeSeen;                        // sticky wake flag
    logic [1:0][NUM_IRQ-1:0] pend;         // latched irqs per core
    logic ignore;                          // registered clock ignore
    logic [31:0] rdata;                    // read data
  } state_t;
  state_t st_q, st_d;

  // synchronised link pins
  logic bitClkSync;
  logic sdiSync;
  pin_sync3 uBitClkSync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pinIn(bitClkPin),
    .pinOut(bitClkSync)
  );
  pin_sync3 uSdiSync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pinIn(serialDataIn),
    .pinOut(sdiSync)
  );

  // apb strobes: zero wait state slave
  logic wrEn;
  logic rdEn;
  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // per core handshake gathered into vectors
  logic [1:0] idleExec;
  logic [1:0] rtiExec;
  logic [1:0] intsDis;
  assign idleExec = {core2IdleExec, core1IdleExec};
  assign rtiExec = {core2RtiExec, core1RtiExec};
  assign intsDis = {core2IntsDisabled, core1IntsDisabled};

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [31:0] w;
    logic bitRise;
    logic wake;
    logic allDown;
    logic [1:0] pdWr;
    logic [1:0] puWr;
    logic goCold;
    logic goWarm;
    w = pwdata;
    st_d = st_q;
    bitRise = bitClkSync & ~st_q.bitClkPrev;
    st_d.bitClkPrev = bitClkSync;
    pdWr = '0;
    puWr = '0;
    wake = 1'b0;
    allDown = 1'b0;
    goCold = 1'b0;
    goWarm = 1'b0;
    // register writes
    if (wrEn) begin
      unique case (paddr)
        lp_ctrl_pkg::CLOCK_MODE_OFS: st_d.clkMode = w[2:0];
        lp_ctrl_pkg::CORE1_PWR_OFS: begin
          pdWr[0] = w[lp_ctrl_pkg::PWR_DOWN_BIT];
          puWr[0] = w[lp_ctrl_pkg::PWR_UP_BIT];
        end
        lp_ctrl_pkg::CORE2_PWR_OFS: begin
          pdWr[1] = w[lp_ctrl_pkg::PWR_DOWN_BIT];
          puWr[1] = w[lp_ctrl_pkg::PWR_UP_BIT];
        end
        lp_ctrl_pkg::LINK_CTRL_OFS: begin
          st_d.linkCtl = w[1:0];
          // write one clears wake flag; a fresh wake below wins
          if (w[lp_ctrl_pkg::WAKE_SEEN_BIT]) begin
            st_d.wakeSeen = 1'b0;
          end
          // software power down of the link, applied after the sequencer
          goCold = w[lp_ctrl_pkg::LINK_COLD_BIT];
          goWarm = w[lp_ctrl_pkg::LINK_WARM_BIT];
        end
        default: ;
      endcase
    end
    // core power sequencing, one loop iteration per core
    for (int c = 0; c < 2; c++) begin
      // powerdown request stays pending until the irq can be taken
      if (pdWr[c]) begin
        st_d.pdReq[c] = 1'b1;
      end
      unique case (st_q.core[c])
        lp_ctrl_pkg::CORE_RUN: begin
          // unmaskable but held off by global disable
          if (st_q.pdReq[c] && !intsDis[c]) begin
            st_d.core[c] = lp_ctrl_pkg::CORE_HANDLER;
            st_d.pdReq[c] = pdWr[c];
            st_d.irqOut[c] = 1'b1;
          end
        end
        lp_ctrl_pkg::CORE_HANDLER: begin
          st_d.irqOut[c] = 1'b0;
          if (rtiExec[c]) begin
            st_d.core[c] = lp_ctrl_pkg::CORE_RUN;
          end else if (idleExec[c] && !puWr[c]) begin
            st_d.core[c] = lp_ctrl_pkg::CORE_DOWN;
          end
        end
        lp_ctrl_pkg::CORE_DOWN: begin
          // powerup releases the idle; handler then returns
          if (puWr[c]) begin
            st_d.core[c] = lp_ctrl_pkg::CORE_HANDLER;
          end
        end
        default: st_d.core[c] = lp_ctrl_pkg::CORE_RUN;
      endcase
      // irq latching: set wins over acknowledge
      st_d.pend[c] = (st_q.pend[c] & ~(irqAck[c] ? st_q.pend[c] : '0)) | irqIn;
    end
    // wake detection differs by link state
    if (st_q.link == lp_ctrl_pkg::LINK_RUN) begin
      wake = bitRise && (st_q.bitCnt == 8'(lp_ctrl_pkg::WAKE_BIT_POS)) && sdiSync;
    end else begin
      wake = sdiSync;
    end
    if (wake) begin
      st_d.wakeSeen = 1'b1;
    end
    // frame bit counter, advanced on bitclk rising edges
    if (st_q.link != lp_ctrl_pkg::LINK_RUN) begin
      st_d.bitCnt = '0;
    end else if (bitRise) begin
      st_d.bitCnt = (st_q.bitCnt == 8'(lp_ctrl_pkg::FRAME_BITS - 1)) ? 8'h00 : st_q.bitCnt + 8'h01;
    end
    // link sequencer
    unique case (st_q.link)
      lp_ctrl_pkg::LINK_COLD: begin
        if (st_q.linkCtl[0] || (wake && st_q.linkCtl[1])) begin
          st_d.link = lp_ctrl_pkg::LINK_IDLE;
        end
      end
      lp_ctrl_pkg::LINK_WARM: begin
        if (st_q.linkCtl[0] || (wake && st_q.linkCtl[1])) begin
          st_d.link = lp_ctrl_pkg::LINK_WAKE;
          st_d.syncCnt = 8'(lp_ctrl_pkg::WAKE_SYNC_CYC);
        end
      end
      lp_ctrl_pkg::LINK_WAKE: begin
        // sync held high for the wake interval
        if (st_q.syncCnt == 8'h01) begin
          st_d.link = lp_ctrl_pkg::LINK_IDLE;
        end
        st_d.syncCnt = st_q.syncCnt - 8'h01;
      end
      lp_ctrl_pkg::LINK_IDLE: begin
        // bitclk running, no sync until enabled
        if (st_q.linkCtl[0] && bitRise) begin
          st_d.link = lp_ctrl_pkg::LINK_RUN;
        end
      end
      lp_ctrl_pkg::LINK_RUN: ;
      default: st_d.link = lp_ctrl_pkg::LINK_COLD;
    endcase
    // software power down wins over a sequencer step in the same cycle,
    // otherwise a bitclk edge in idle could swallow the request
    if (goCold) begin
      st_d.link = lp_ctrl_pkg::LINK_COLD;
    end else if (goWarm) begin
      st_d.link = lp_ctrl_pkg::LINK_WARM;
    end
    // clock ignore, recomputed every cycle
    allDown = (st_q.core[0] == lp_ctrl_pkg::CORE_DOWN) &&
              (st_q.core[1] == lp_ctrl_pkg::CORE_DOWN) &&
              ((st_q.link == lp_ctrl_pkg::LINK_COLD) || (st_q.link == lp_ctrl_pkg::LINK_WARM)) &&
              !st_q.clkMode[lp_ctrl_pkg::XTAL_FORCE_BIT];
    unique case (lp_ctrl_pkg::host_mode_t'(st_q.clkMode[1:0]))
      lp_ctrl_pkg::HOST_PCI, lp_ctrl_pkg::HOST_CARDBUS: st_d.ignore = allDown;
      lp_ctrl_pkg::HOST_USB: st_d.ignore = allDown && usbSuspended;
      lp_ctrl_pkg::HOST_SUBISA: st_d.ignore = 1'b0;
    endcase
    // read data captured in setup phase
    if (rdEn) begin
      unique case (paddr)
        lp_ctrl_pkg::CLOCK_MODE_OFS: st_d.rdata = {29'h0, st_q.clkMode};
        lp_ctrl_pkg::CORE1_PWR_OFS:
          st_d.rdata = {30'h0, st_q.core[0] != lp_ctrl_pkg::CORE_RUN,
                        st_q.core[0] == lp_ctrl_pkg::CORE_DOWN};
        lp_ctrl_pkg::CORE2_PWR_OFS:
          st_d.rdata = {30'h0, st_q.core[1] != lp_ctrl_pkg::CORE_RUN,
                        st_q.core[1] == lp_ctrl_pkg::CORE_DOWN};
        lp_ctrl_pkg::LINK_CTRL_OFS: st_d.rdata = {27'h0, st_q.wakeSeen, 2'h0, st_q.linkCtl};
        lp_ctrl_pkg::STATUS_OFS: st_d.rdata = {28'h0, st_q.ignore, st_q.link};
        lp_ctrl_pkg::PENDING_OFS: st_d.rdata = 32'(st_q.pend);
        default: st_d.rdata = 32'h0;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = st_q.rdata;
  assign codecLinkResetN = (st_q.link != lp_ctrl_pkg::LINK_COLD);
  assign bitClkEnable = (st_q.link == lp_ctrl_pkg::LINK_IDLE) ||
                        (st_q.link == lp_ctrl_pkg::LINK_RUN);
  assign frameSync = (st_q.link == lp_ctrl_pkg::LINK_WAKE) ||
                     ((st_q.link == lp_ctrl_pkg::LINK_RUN) && (st_q.bitCnt < 8'h10));
  assign core1PwrIrq = st_q.irqOut[0];
  assign core2PwrIrq = st_q.irqOut[1];
  assign core1PwrVector = lp_ctrl_pkg::PWR_VECTOR;
  assign core2PwrVector = lp_ctrl_pkg::PWR_VECTOR;
  assign core1ClkStop = (st_q.core[0] == lp_ctrl_pkg::CORE_DOWN);
  assign core2ClkStop = (st_q.core[1] == lp_ctrl_pkg::CORE_DOWN);
  assign core1IrqPend = st_q.pend[0];
  assign core2IrqPend = st_q.pend[1];
  assign extClkIgnore = st_q.ignore;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence warmWakeSeq;
    (st_q.link == lp_ctrl_pkg::LINK_WARM) && st_q.linkCtl[0];
  endsequence
  subisa_never_ignore_a: assert property (
    (st_q.clkMode[1:0] == 2'b11) |=> !extClkIgnore)
    else $error("clock ignored in sub-isa mode");
  ignore_needs_down_a: assert property (
    extClkIgnore |-> $past(core1ClkStop && core2ClkStop && !bitClkEnable && !frameSync &&
                           !st_q.clkMode[lp_ctrl_pkg::XTAL_FORCE_BIT]))
    else $error("clock ignored while not all down");
  usb_suspend_need_a: assert property (
    ($past(st_q.clkMode[1:0]) == 2'b10 && extClkIgnore) |-> $past(usbSuspended))
    else $error("usb clock ignored without suspend");
  cold_pins_a: assert property (
    !codecLinkResetN |-> (!bitClkEnable && !frameSync))
    else $error("cold link drives clocks");
  warm_sync_pulse_a: assert property (
    warmWakeSeq |=> frameSync [*8] ##0 (st_q.syncCnt > 8'h00))
    else $error("warm wake sync pulse too short");
  idle_no_sync_a: assert property (
    (st_q.link == lp_ctrl_pkg::LINK_IDLE) |-> (bitClkEnable && !frameSync))
    else $error("idle link emits sync");
  irq_masked_dis_a: assert property (
    (core1IntsDisabled && !core1PwrIrq) |=> !core1PwrIrq)
    else $error("powerdown irq taken while disabled");
  rti_cancel_a: assert property (
    (st_q.core[0] == lp_ctrl_pkg::CORE_HANDLER && core1RtiExec) |=> !core1ClkStop)
    else $error("return did not cancel powerdown");
  irq_latched_a: assert property (
    (irqIn[0] && core1ClkStop) |=> core1IrqPend[0])
    else $error("irq lost in powerdown");
endmodule // lp_clock_link_ctrl
`default_nettype wire

// *** dv/codec_model.sv ***
// partner model: external codec making the bit clock and the serial data input
`timescale 1ns/1ns
`default_nettype none
module codec_model (
  // link outputs of the controller
  input wire logic codecLinkResetN,
  input wire logic bitClkEnable,
  input wire logic frameSync,
  // wake request commanded by the bench
  input wire logic wakeReq,
  // pins towards the controller
  output logic bitClkPin,
  output logic serialDataIn
);
  // ****************************************
  // bit clock and frame tracking
  // ****************************************
  int bitIdx = 0; // bit position in the current frame
  logic syncQ = 1'b0; // frame sync seen at the previous bit clock edge
  logic inFrames = 1'b0; // link is running with frames
  // 80 ns bit clock, odd phase offset; stands low unless enabled and out of reset
  initial begin
    bitClkPin = 1'b0;
    #3;
    forever begin
      #40;
      bitClkPin = (bitClkEnable && codecLinkResetN) ? ~bitClkPin : 1'b0;
    end
  end
  // frame start on the first bit clock edge that sees sync high
  always @(posedge bitClkPin) begin
    bitIdx = (frameSync && !syncQ) ? 0 : bitIdx + 1;
    syncQ = frameSync;
    if (frameSync) inFrames = 1'b1;
  end
  // framed mode ends when the bit clock is switched off
  always @(negedge bitClkEnable) inFrames = 1'b0;
  // wake: end of slot 12 region while framed (margin for sync delay), else a level
  // line is pulled low when no wake is requested
  assign serialDataIn = inFrames ? (wakeReq && bitIdx >= 232) : wakeReq;
endmodule // codec_model
`default_nettype wire

// *** dv/tb_top.sv ***
// testbench: directed and random checks of the low power clock and link control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ****************************************
  // signals, design and partner
  // ****************************************
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic usbSuspended = 1'b0;
  logic wakeReq = 1'b0;
  logic [1:0] idleExec = 2'h0;
  logic [1:0] rtiExec = 2'h0;
  logic [1:0] intsDis = 2'h0;
  logic [7:0] irqIn = 8'h00;
  logic [1:0] irqAck = 2'h0;
  wire logic [31:0] prdata;
  wire logic pready, bitClkPin, serialDataIn, codecLinkResetN, bitClkEnable, frameSync;
  wire logic extClkIgnore;
  wire logic pslverr;
  wire logic [1:0] pwrIrq, clkStop;
  wire logic [15:0] vec1, vec2;
  wire logic [7:0] pend1, pend2;
  int numErrors = 0;
  int cmpCount = 0;
  int irqCnt0 = 0;
  int irqCnt1 = 0;
  // core clock always running, in every host mode
  always #4 core_clk = ~core_clk;
  // count powerdown interrupt pulses per core
  always @(posedge core_clk) begin
    if (pwrIrq[0] === 1'b1) irqCnt0++;
    if (pwrIrq[1] === 1'b1) irqCnt1++;
  end
  lp_clock_link_ctrl #(.NUM_IRQ(8)) uut (
    .core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .usbSuspended, .bitClkPin, .serialDataIn, .codecLinkResetN, .bitClkEnable,
    .frameSync, .core1IdleExec(idleExec[0]), .core1RtiExec(rtiExec[0]),
    .core1IntsDisabled(intsDis[0]), .core1PwrIrq(pwrIrq[0]), .core1PwrVector(vec1),
    .core1ClkStop(clkStop[0]), .core2IdleExec(idleExec[1]), .core2RtiExec(rtiExec[1]),
    .core2IntsDisabled(intsDis[1]), .core2PwrIrq(pwrIrq[1]), .core2PwrVector(vec2),
    .core2ClkStop(clkStop[1]), .irqIn, .irqAck, .core1IrqPend(pend1), .core2IrqPend(pend2),
    .extClkIgnore);
  codec_model codec (.codecLinkResetN, .bitClkEnable, .frameSync, .wakeReq, .bitClkPin,
    .serialDataIn);
  // compare and count
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmpCount++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer: setup, access, wait for pready
  task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 50) numErrors++;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    apbXfer(1'b1, a, d, v);
  endtask
  // read until the masked value matches or tries run out, then compare
  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp, input int tries);
    logic [31:0] v;
    int n;
    n = 0;
    do begin
      apbXfer(1'b0, a, 32'h0, v);
      n++;
    end while ((v & m) !== exp && n < tries);
    check(what, exp, v & m);
  endtask
  // let edges pass, then sample at the falling edge
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // one-cycle idle or return pulse from a core
  task automatic corePulse(input logic idle, input int c);
    @(posedge core_clk);
    if (idle) idleExec[c] <= 1'b1;
    else rtiExec[c] <= 1'b1;
    @(posedge core_clk);
    idleExec <= 2'h0;
    rtiExec <= 2'h0;
  endtask
  // expected clock ignore with both cores and the link down
  function automatic logic ignoreExp(input logic [1:0] m, input logic x, input logic u);
    return m != 2'h3 && !x && (m != 2'h2 || u);
  endfunction
  task automatic endOfTest();
    $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (60000) @(posedge core_clk);
    numErrors++;
    endOfTest();
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    logic [7:0] irqVal;
    logic [1:0] mode;
    logic xtal;
    int n;
    void'($urandom(68046));
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    settle(0);
    check("linkPins", 3'b000, {codecLinkResetN, bitClkEnable, frameSync});
    rdChk("status", lp_ctrl_pkg::STATUS_OFS, 32'hf, 32'h0, 1);
    rdChk("unmapped", 8'h1c, 32'hffffffff, 32'h0, 1);
    check("slvErr", 0, pslverr);
    // core 1 request held off while interrupts are disabled
    @(posedge core_clk);
    intsDis[0] <= 1'b1;
    wr(lp_ctrl_pkg::CORE1_PWR_OFS, 32'h1);
    settle(4);
    check("irqBlocked", 0, irqCnt0);
    @(posedge core_clk);
    intsDis[0] <= 1'b0;
    settle(3);
    check("irqTaken", 1, irqCnt0);
    check("vector", lp_ctrl_pkg::PWR_VECTOR, vec1);
    check("vector2", lp_ctrl_pkg::PWR_VECTOR, vec2);
    check("stopEarly", 0, clkStop[0]);
    rdChk("handler1", lp_ctrl_pkg::CORE1_PWR_OFS, 32'h3, 32'h2, 1);
    corePulse(1'b1, 0);
    settle(1);
    check("stopIdle", 1, clkStop[0]);
    rdChk("down1", lp_ctrl_pkg::CORE1_PWR_OFS, 32'h3, 32'h3, 1);
    // core 2 handler reused: return without idle
    wr(lp_ctrl_pkg::CORE2_PWR_OFS, 32'h1);
    settle(3);
    corePulse(1'b0, 1);
    settle(1);
    check("irq2", 1, irqCnt1);
    rdChk("back2", lp_ctrl_pkg::CORE2_PWR_OFS, 32'h3, 32'h0, 1);
    wr(lp_ctrl_pkg::CORE2_PWR_OFS, 32'h1);
    settle(3);
    corePulse(1'b1, 1);
    settle(1);
    check("stop2", 1, clkStop[1]);
    // interrupts latched while both cores sleep
    irqVal = 8'($urandom) | 8'h01;
    @(posedge core_clk);
    irqIn <= irqVal;
    @(posedge core_clk);
    irqIn <= 8'h00;
    settle(2);
    check("pend1", irqVal, pend1);
    rdChk("pendReg", lp_ctrl_pkg::PENDING_OFS, 32'hffff, {16'h0, irqVal, irqVal}, 1);
    @(posedge core_clk);
    irqAck <= 2'h1;
    @(posedge core_clk);
    irqAck <= 2'h0;
    rdChk("pendAck", lp_ctrl_pkg::PENDING_OFS, 32'hffff, {16'h0, irqVal, 8'h00}, 1);
    // host modes, crystal force and usb suspend: fixed cases then random
    for (int i = 0; i < 16; i++) begin
      mode = (i < 8) ? 2'(i) : 2'($urandom);
      xtal = (i < 8) ? 1'b0 : 1'($urandom);
      @(posedge core_clk);
      usbSuspended <= (i < 4) ? 1'b1 : (i < 8) ? 1'b0 : 1'($urandom);
      wr(lp_ctrl_pkg::CLOCK_MODE_OFS, {29'h0, xtal, mode});
      settle(2);
      check("ignore", ignoreExp(mode, xtal, usbSuspended), extClkIgnore);
    end
    wr(lp_ctrl_pkg::CLOCK_MODE_OFS, 32'h0);
    settle(2);
    check("ignorePci", 1, extClkIgnore);
    wr(lp_ctrl_pkg::CORE1_PWR_OFS, 32'h2);
    settle(2);
    check("ignoreUp", 0, extClkIgnore);
    check("stopUp", 0, clkStop[0]);
    // link: cold to idle to running
    wr(lp_ctrl_pkg::LINK_CTRL_OFS, 32'h1);
    settle(1);
    check("idlePins", 3'b110, {codecLinkResetN, bitClkEnable, frameSync});
    rdChk("idle", lp_ctrl_pkg::STATUS_OFS, 32'h7, 32'h3, 1);
    rdChk("run", lp_ctrl_pkg::STATUS_OFS, 32'h7, 32'h4, 3000);
    @(posedge core_clk);
    wakeReq <= 1'b1;
    rdChk("wakeRun", lp_ctrl_pkg::LINK_CTRL_OFS, 32'h10, 32'h10, 3000);
    @(posedge core_clk);
    wakeReq <= 1'b0;
    wr(lp_ctrl_pkg::LINK_CTRL_OFS, 32'h11);
    // warm powerdown and the timed sync wake
    wr(lp_ctrl_pkg::LINK_CTRL_OFS, 32'h8);
    settle(1);
    check("warmPins", 3'b100, {codecLinkResetN, bitClkEnable, frameSync});
    rdChk("warm", lp_ctrl_pkg::STATUS_OFS, 32'h7, 32'h1, 1);
    wr(lp_ctrl_pkg::LINK_CTRL_OFS, 32'h1);
    n = 0;
    while (frameSync !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    n = 0;
    while (frameSync === 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    check("syncPulse", lp_ctrl_pkg::WAKE_SYNC_CYC, n);
    // cold powerdown, wake by level, restart only when enabled
    wr(lp_ctrl_pkg::LINK_CTRL_OFS, 32'h14);
    settle(1);
    check("coldPins", 3'b000, {codecLinkResetN, bitClkEnable, frameSync});
    rdChk("noWake", lp_ctrl_pkg::LINK_CTRL_OFS, 32'h10, 32'h0, 1);
    @(posedge core_clk);
    wakeReq <= 1'b1;
    rdChk("wakeCold", lp_ctrl_pkg::LINK_CTRL_OFS, 32'h10, 32'h10, 100);
    rdChk("stayCold", lp_ctrl_pkg::STATUS_OFS, 32'h7, 32'h0, 1);
    wr(lp_ctrl_pkg::LINK_CTRL_OFS, 32'h2);
    settle(20);
    check("restart", 1, codecLinkResetN);
    endOfTest();
  end
endmodule // tb_top
`default_nettype wire
